// [design/adc_consts.svh]
// Register map, field positions, reset values and timing counts of the converter sequencer
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_PINCFG 8'h04
`define OFS_ACQCLK 8'h08
`define OFS_RESULT 8'h0C
`define OFS_STATUS 8'h10
`define OFS_PORT 8'h14

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_GO_BIT 1
`define CTRL_CHAN_LSB 2
`define ACQCLK_CLK_LSB 0
`define ACQCLK_ACQ_LSB 3
`define ACQCLK_JUST_BIT 7
`define STATUS_DONE_BIT 0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ACQ_SEL_RST 3'h0
`define CLK_SEL_RST 3'h0
`define JUSTIFY_RST 1'h0
`define CHAN_RST 4'h0
`define PCFG_HI_RST 1'h0
`define PCFG_LO_STRAP1 3'h0
`define PCFG_LO_STRAP0 3'h7
`define RESULT_RST 16'h0000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SYS_CLK_PERIOD_NS 8
`define INSTR_CYCLE_NS 32
`define INSTR_CYCLE_CLKS ((`INSTR_CYCLE_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define CONV_PERIODS 5'h0B
`define POST_WAIT_PERIODS 5'h02
`define SAR_MSB_TRIAL 10'h200

// Divider terminal counts (bit period minus one)
`define DIV_TC_2 6'h01
`define DIV_TC_4 6'h03
`define DIV_TC_8 6'h07
`define DIV_TC_16 6'h0F
`define DIV_TC_32 6'h1F
`define DIV_TC_64 6'h3F

// Programmed acquisition lengths in bit periods
`define ACQ_LEN_1 5'h02
`define ACQ_LEN_2 5'h04
`define ACQ_LEN_3 5'h06
`define ACQ_LEN_4 5'h08
`define ACQ_LEN_5 5'h0C
`define ACQ_LEN_6 5'h10
`define ACQ_LEN_7 5'h14

// Analog pin configuration decode
`define NUM_AN 13
`define PCFG_ALL_ANALOG_MAX 4'h2
`define PCFG_COUNT_BASE 5'h0F
`define NUM_AN_COUNT 5'h0D

`endif

// [design/adc_pkg.sv]
// Types shared by the converter sequencer and its bit period divider
package adc_pkg;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SAMPLE,
        ST_ACQ,
        ST_DELAY,
        ST_CONV,
        ST_WAIT
    } state_type;

    // ------------------------------------------------------------
    // Whole sequencer state
    // ------------------------------------------------------------
    typedef struct packed {
        state_type state;
        logic enable;
        logic go;
        logic [3:0] chan;
        logic [3:0] pcfg;
        logic justify;
        logic [2:0] acq_sel;
        logic [2:0] clk_sel;
        logic [15:0] result;
        logic done_flag;
        logic [4:0] cnt;
        logic [9:0] sar;
        logic sampling;
        logic [31:0] rdata;
        logic [1:0] cmp_sync;
        logic [1:0] strap_sync;
        logic [12:0] pin_s1;
        logic [12:0] pin_s2;
        logic [2:0] rc_sync;
    } seq_state_type;

    // ------------------------------------------------------------
    // Divider state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] count;
        logic tick;
    } div_state_type;

endpackage

// [design/bit_period_divider.sv]
// Free-running divider giving one tick per conversion bit period
`timescale 1ns/1ps
`include "adc_consts.svh"

module bit_period_divider (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Selection
    input wire logic [2:0] conversion_clock_select,
    input wire logic rc_rise,
    // Bit period pulse
    output logic tick
);

    adc_pkg::div_state_type s;
    adc_pkg::div_state_type next_s;
    logic [5:0] tc;

    // Terminal count per clock select code
    always_comb begin
        case (conversion_clock_select)
            3'h0: tc = `DIV_TC_2;
            3'h4: tc = `DIV_TC_4;
            3'h1: tc = `DIV_TC_8;
            3'h5: tc = `DIV_TC_16;
            3'h2: tc = `DIV_TC_32;
            3'h6: tc = `DIV_TC_64;
            default: tc = `DIV_TC_2;
        endcase
    end

    // Counter free-runs so a period never waits on software
    always_comb begin
        next_s = s;
        if (conversion_clock_select[1:0] == 2'h3) begin
            next_s.count = 6'h00;
            next_s.tick = rc_rise;
        end else if (s.count >= tc) begin
            next_s.count = 6'h00;
            next_s.tick = 1'b1;
        end else begin
            next_s.count = s.count + 6'h01;
            next_s.tick = 1'b0;
        end
        if (rst) begin
            next_s.count = 6'h00;
            next_s.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    assign tick = s.tick;

endmodule

// [design/adc_sequencer.sv]
// Acquisition and conversion sequencer of a 10-bit successive approximation converter
//
// Functional notes
// - Go with nonzero acquisition code samples the programmed periods, then converts.
// - Go with acquisition code 000 stops sampling and converts at once.
// - Acquisition select resets to the manual code 000.
// - Completion clears go, sets the complete flag, resumes sampling.
// - No status tells acquisition from conversion; go stays set through both.
// - A conversion lasts exactly 11 bit periods; here it ends on the 11th divider tick, after 10 to 11 periods.
// - Clock select 000/100/001/101/010/110 give 2..64 periods; x11 selects RC.
// - RC clock with manual acquisition delays conversion by one instruction cycle.
// - Clearing go aborts conversion; result pair keeps its old value.
// - After completion or abort wait two bit periods, then sample again.
// - Conversion works regardless of pin direction bits.
// - Port reads return zero for pins configured as analog inputs.
// - Low pin config bits reset to 000 with strap high, 111 when low.
// - Justify bit 1 gives right justified result, 0 left justified.
// - Acquisition codes 001..111 give 2,4,6,8,12,16,20 bit periods.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "adc_consts.svh"

module adc_sequencer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog front end
    input wire logic comparator_high,
    input wire logic rc_clk_in,
    output logic hold_capacitor_connect,
    output logic [9:0] dac_code,
    output logic [3:0] channel_select,
    // Port pins and strap
    input wire logic [12:0] port_pins,
    input wire logic portb_analog_reset_cfg,
    // Status levels
    output logic conversion_complete_flag,
    output logic conversion_busy
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    adc_pkg::seq_state_type s;
    adc_pkg::seq_state_type next_s;
    logic tick;
    logic rc_rise;
    logic [4:0] acq_len;
    logic [4:0] analog_count;
    logic [12:0] analog_mask;
    logic [12:0] port_read;
    logic [15:0] justified;
    logic [9:0] sar_final;
    logic [3:0] bit_idx;
    logic mapped;
    logic wr_access;
    logic rd_setup;
    logic wr_ctrl;
    logic [31:0] rd_mux;
    logic [4:0] instr_clks;

    // ------------------------------------------------------------
    // Bit period source
    // ------------------------------------------------------------
    // RC clock edge seen only after two sync stages
    assign rc_rise = s.rc_sync[1] & ~s.rc_sync[2];

    bit_period_divider u_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .conversion_clock_select(s.clk_sel),
        .rc_rise(rc_rise),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    // Programmed acquisition length per code
    always_comb begin
        case (s.acq_sel)
            3'h1: acq_len = `ACQ_LEN_1;
            3'h2: acq_len = `ACQ_LEN_2;
            3'h3: acq_len = `ACQ_LEN_3;
            3'h4: acq_len = `ACQ_LEN_4;
            3'h5: acq_len = `ACQ_LEN_5;
            3'h6: acq_len = `ACQ_LEN_6;
            3'h7: acq_len = `ACQ_LEN_7;
            default: acq_len = 5'h00;
        endcase
    end

    // Number of analog channels for the pin configuration
    always_comb begin
        if (s.pcfg <= `PCFG_ALL_ANALOG_MAX) begin
            analog_count = `NUM_AN_COUNT;
        end else begin
            analog_count = `PCFG_COUNT_BASE - {1'b0, s.pcfg};
        end
    end

    // Analog pins read low on port reads
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_AN; gi = gi + 1) begin : g_pin
            assign analog_mask[gi] = (5'(gi) < analog_count);
            assign port_read[gi] = s.pin_s2[gi] & ~analog_mask[gi];
        end
    endgenerate

    // Final code with the last bit resolved
    assign sar_final = {s.sar[9:1], s.cmp_sync[1]};

    // Result placement in the pair
    always_comb begin
        if (s.justify) begin
            justified = {6'h00, sar_final};
        end else begin
            justified = {sar_final, 6'h00};
        end
    end

    assign instr_clks = 5'(`INSTR_CYCLE_CLKS);
    assign bit_idx = 4'h9 - s.cnt[3:0];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign wr_access = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign mapped = (paddr == `OFS_CTRL) | (paddr == `OFS_PINCFG)
        | (paddr == `OFS_ACQCLK) | (paddr == `OFS_RESULT)
        | (paddr == `OFS_STATUS) | (paddr == `OFS_PORT);
    assign wr_ctrl = wr_access & (paddr == `OFS_CTRL);

    // Read mux; go reads set through acquisition and conversion alike
    always_comb begin
        rd_mux = 32'h00000000;
        case (paddr)
            `OFS_CTRL: begin
                rd_mux[`CTRL_EN_BIT] = s.enable;
                rd_mux[`CTRL_GO_BIT] = s.go;
                rd_mux[`CTRL_CHAN_LSB +: 4] = s.chan;
            end
            `OFS_PINCFG: rd_mux[3:0] = s.pcfg;
            `OFS_ACQCLK: begin
                rd_mux[`ACQCLK_CLK_LSB +: 3] = s.clk_sel;
                rd_mux[`ACQCLK_ACQ_LSB +: 3] = s.acq_sel;
                rd_mux[`ACQCLK_JUST_BIT] = s.justify;
            end
            `OFS_RESULT: rd_mux[15:0] = s.result;
            `OFS_STATUS: rd_mux[`STATUS_DONE_BIT] = s.done_flag;
            `OFS_PORT: rd_mux[12:0] = port_read;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Two-stage synchronisers for pins and the RC clock
        next_s.cmp_sync = {s.cmp_sync[0], comparator_high};
        next_s.strap_sync = {s.strap_sync[0], portb_analog_reset_cfg};
        next_s.pin_s1 = port_pins;
        next_s.pin_s2 = s.pin_s1;
        next_s.rc_sync = {s.rc_sync[1:0], rc_clk_in};

        // Read data captured in setup so it is steady in access
        if (rd_setup) begin
            next_s.rdata = rd_mux;
        end

        // Register writes
        if (wr_ctrl) begin
            next_s.enable = pwdata[`CTRL_EN_BIT];
            next_s.go = pwdata[`CTRL_GO_BIT];
            next_s.chan = pwdata[`CTRL_CHAN_LSB +: 4];
        end
        if (wr_access && paddr == `OFS_PINCFG) begin
            next_s.pcfg = pwdata[3:0];
        end
        if (wr_access && paddr == `OFS_ACQCLK) begin
            next_s.clk_sel = pwdata[`ACQCLK_CLK_LSB +: 3];
            next_s.acq_sel = pwdata[`ACQCLK_ACQ_LSB +: 3];
            next_s.justify = pwdata[`ACQCLK_JUST_BIT];
        end
        if (wr_access && paddr == `OFS_RESULT) begin
            next_s.result = pwdata[15:0];
        end
        // Write one to clear; a completion in the same cycle wins below
        if (wr_access && paddr == `OFS_STATUS && pwdata[`STATUS_DONE_BIT]) begin
            next_s.done_flag = 1'b0;
        end

        // Sequencer
        case (s.state)
            adc_pkg::ST_SAMPLE: begin
                next_s.sampling = 1'b1;
                if (s.go && s.enable) begin
                    next_s.cnt = 5'h00;
                    if (s.acq_sel != 3'h0) begin
                        next_s.state = adc_pkg::ST_ACQ;
                    end else if (s.clk_sel[1:0] == 2'h3) begin
                        next_s.state = adc_pkg::ST_DELAY;
                        next_s.sampling = 1'b0;
                    end else begin
                        next_s.state = adc_pkg::ST_CONV;
                        next_s.sampling = 1'b0;
                        next_s.sar = `SAR_MSB_TRIAL;
                    end
                end
            end
            adc_pkg::ST_ACQ: begin
                // Hold capacitor keeps tracking the input meanwhile
                if (!s.go || !s.enable) begin
                    next_s.state = adc_pkg::ST_WAIT;
                    next_s.cnt = 5'h00;
                end else if (tick) begin
                    if (s.cnt + 5'h01 >= acq_len) begin
                        next_s.state = adc_pkg::ST_CONV;
                        next_s.cnt = 5'h00;
                        next_s.sampling = 1'b0;
                        next_s.sar = `SAR_MSB_TRIAL;
                    end else begin
                        next_s.cnt = s.cnt + 5'h01;
                    end
                end
            end
            adc_pkg::ST_DELAY: begin
                // Leaves time for the sleep instruction to retire
                if (!s.go || !s.enable) begin
                    next_s.state = adc_pkg::ST_WAIT;
                    next_s.cnt = 5'h00;
                end else if (s.cnt + 5'h01 >= instr_clks) begin
                    next_s.state = adc_pkg::ST_CONV;
                    next_s.cnt = 5'h00;
                    next_s.sampling = 1'b0;
                    next_s.sar = `SAR_MSB_TRIAL;
                end else begin
                    next_s.cnt = s.cnt + 5'h01;
                end
            end
            adc_pkg::ST_CONV: begin
                if (!s.go || !s.enable) begin
                    // Partial code is dropped, result untouched
                    next_s.state = adc_pkg::ST_WAIT;
                    next_s.cnt = 5'h00;
                end else if (tick) begin
                    if (s.cnt + 5'h01 >= `CONV_PERIODS) begin
                        next_s.state = adc_pkg::ST_WAIT;
                        next_s.cnt = 5'h00;
                        next_s.result = justified;
                        next_s.go = 1'b0;
                        next_s.done_flag = 1'b1;
                    end else begin
                        next_s.cnt = s.cnt + 5'h01;
                        // One bit decided per period, MSB first
                        if (s.cnt < 5'h0A) begin
                            next_s.sar[bit_idx] = s.cmp_sync[1];
                            if (bit_idx != 4'h0) begin
                                next_s.sar[bit_idx - 4'h1] = 1'b1;
                            end
                        end
                    end
                end
            end
            adc_pkg::ST_WAIT: begin
                if (tick) begin
                    if (s.cnt + 5'h01 >= `POST_WAIT_PERIODS) begin
                        next_s.state = adc_pkg::ST_SAMPLE;
                        next_s.cnt = 5'h00;
                        next_s.sampling = 1'b1;
                    end else begin
                        next_s.cnt = s.cnt + 5'h01;
                    end
                end
            end
            default: begin
                next_s.state = adc_pkg::ST_SAMPLE;
                next_s.cnt = 5'h00;
            end
        endcase

        // Synchronous reset keeps the synchronisers running
        if (rst) begin
            next_s.state = adc_pkg::ST_SAMPLE;
            next_s.enable = 1'b0;
            next_s.go = 1'b0;
            next_s.chan = `CHAN_RST;
            next_s.acq_sel = `ACQ_SEL_RST;
            next_s.clk_sel = `CLK_SEL_RST;
            next_s.justify = `JUSTIFY_RST;
            next_s.result = `RESULT_RST;
            next_s.done_flag = 1'b0;
            next_s.cnt = 5'h00;
            next_s.sar = 10'h000;
            next_s.sampling = 1'b1;
            next_s.rdata = 32'h00000000;
            if (s.strap_sync[1]) begin
                next_s.pcfg = {`PCFG_HI_RST, `PCFG_LO_STRAP1};
            end else begin
                next_s.pcfg = {`PCFG_HI_RST, `PCFG_LO_STRAP0};
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero-wait slave: every access ends in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = s.rdata;
    // Channel drives the mux whatever the pin direction bits say
    assign channel_select = s.chan;
    assign hold_capacitor_connect = s.sampling;
    assign dac_code = s.sar;
    assign conversion_complete_flag = s.done_flag;
    assign conversion_busy = s.go;

endmodule

// [dv/adc_sequencer_chk.sv]
// Port-level concurrent checks of the converter sequencer
`timescale 1ns/1ps
`include "adc_consts.svh"

module adc_sequencer_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sequencer outputs
    input wire logic hold_capacitor_connect,
    input wire logic [3:0] channel_select,
    input wire logic conversion_complete_flag,
    input wire logic conversion_busy
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic acc;
    logic mapped;
    logic ctrl_wr;
    logic clr_wr;
    logic [3:0] wr_chan;
    logic [9:0] conv_len;
    // Decode of the access phase
    assign acc = psel && penable;
    assign mapped = paddr inside {`OFS_CTRL, `OFS_PINCFG, `OFS_ACQCLK, `OFS_RESULT,
        `OFS_STATUS, `OFS_PORT};
    assign ctrl_wr = acc && pwrite && paddr == `OFS_CTRL;
    assign clr_wr = acc && pwrite && paddr == `OFS_STATUS && pwdata[0];
    assign wr_chan = pwdata[5:2];
    // Conversion cycles; cleared when go drops so an abort starts afresh
    always_ff @(posedge sys_clk) begin
        if (rst || !conversion_busy) begin
            conv_len <= 10'h000;
        end else if (!hold_capacitor_connect && conv_len != 10'h3FF) begin
            conv_len <= conv_len + 10'h001;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ready_high: assert property (pready) else $error("pready low");
    a_unmapped_error: assert property (pslverr == (acc && !mapped))
        else $error("pslverr does not match address decode");
    a_done_drops_go: assert property ($rose(conversion_complete_flag) |-> $fell(conversion_busy))
        else $error("flag set without go clearing");
    a_flag_sticky: assert property (conversion_complete_flag && !clr_wr |=> conversion_complete_flag)
        else $error("complete flag lost");
    a_go_held: assert property (conversion_busy && !ctrl_wr |=> conversion_busy || $rose(conversion_complete_flag))
        else $error("go dropped early");
    a_conv_length: assert property ($rose(conversion_complete_flag) |-> conv_len >= 10'h014 && conv_len <= 10'h2C8)
        else $error("conversion length out of range");
    a_done_then_wait: assert property ($rose(conversion_complete_flag) |-> !hold_capacitor_connect [*2])
        else $error("sampling resumed without wait");
    a_sample_resumes: assert property ($rose(conversion_complete_flag) |-> ##[1:140] hold_capacitor_connect)
        else $error("sampling did not resume");
    a_sample_stop_go: assert property ($fell(hold_capacitor_connect) |-> conversion_busy || $past(conversion_busy))
        else $error("sampling stopped without go");
    a_channel_follows: assert property (ctrl_wr |=> channel_select == $past(wr_chan))
        else $error("channel select not updated");
    // Main scenarios
    c_done: cover property ($rose(conversion_complete_flag));
    c_abort: cover property ($fell(conversion_busy) && !$rose(conversion_complete_flag));
    c_unmapped: cover property (acc && pslverr);
    c_acq: cover property (conversion_busy && hold_capacitor_connect [*8]);
endmodule

bind adc_sequencer adc_sequencer_chk chk_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .hold_capacitor_connect(hold_capacitor_connect),
    .channel_select(channel_select), .conversion_complete_flag(conversion_complete_flag),
    .conversion_busy(conversion_busy));

// [dv/tb.sv]
// Self-checking bench of the converter sequencer over APB
`timescale 1ns/1ps
`include "adc_consts.svh"

module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic comparator_high = 1'b1;
    logic rc_clk_in = 1'b0;
    logic [12:0] port_pins = 13'h1FFF;
    logic portb_analog_reset_cfg = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, hold_capacitor_connect, conversion_complete_flag, conversion_busy;
    logic [9:0] dac_code;
    logic [3:0] channel_select;
    int errors = 0;
    int n_tests = 0;
    logic [2:0] clk_codes [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    int acq_lens [7] = '{2, 4, 6, 8, 12, 16, 20};

    // System clock, and an RC clock of 12 periods off the rising edges
    always #4 sys_clk = ~sys_clk;
    always #48 rc_clk_in = ~rc_clk_in;

    adc_sequencer dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_high(comparator_high), .rc_clk_in(rc_clk_in),
        .hold_capacitor_connect(hold_capacitor_connect), .dac_code(dac_code),
        .channel_select(channel_select), .port_pins(port_pins),
        .portb_analog_reset_cfg(portb_analog_reset_cfg),
        .conversion_complete_flag(conversion_complete_flag), .conversion_busy(conversion_busy));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic conclude();
        if (errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; never assumes the answer latency
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            errors++;
            conclude();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        logic e;
        xfer(1'b0, a, 32'h0, q, e);
        chk(what, q, exp);
    endtask

    // Cycles until sampling resumes after a conversion ends
    task automatic wait_hold(input int p, input int slk);
        int w;
        for (w = 0; w < 300; w++) begin
            @(posedge sys_clk);
            if (hold_capacitor_connect === 1'b1) break;
        end
        chk("post wait", 32'(w >= p && w <= 2 * p + 3 + slk), 32'h1);
        if (w == 300) conclude();
    endtask

    // Full conversion on channel 2, phases timed at the pins
    task automatic conv(input logic [7:0] cfg, input int p, input int len, input int dly,
        input int slk, input logic [15:0] exp);
        int acq;
        int cv;
        int w;
        acq = 0;
        cv = 0;
        wr(`OFS_ACQCLK, {24'h000000, cfg});
        wr(`OFS_CTRL, 32'h9);
        wr(`OFS_CTRL, 32'h0000000B);
        for (w = 0; w < 2000; w++) begin
            @(posedge sys_clk);
            if (conversion_busy !== 1'b1) break;
            if (hold_capacitor_connect === 1'b1) acq++;
            else cv++;
        end
        if (w == 2000) begin
            errors++;
            conclude();
        end
        chk("acq phase", 32'(acq >= (len - 1) * p && acq <= len * p + 2 + slk), 32'h1);
        chk("conv phase", 32'(cv >= 10 * p + dly && cv <= 11 * p + 2 + dly + slk), 32'h1);
        wait_hold(p, slk);
        chk("dac code", 32'(dac_code), 32'(cfg[7] ? exp : exp >> 6));
        rd(`OFS_STATUS, 32'h1, "done flag");
        rd(`OFS_CTRL, 32'h9, "go cleared");
        rd(`OFS_RESULT, {16'h0000, exp}, "result");
        wr(`OFS_STATUS, 32'h1);
        rd(`OFS_STATUS, 32'h0, "flag clear");
    endtask

    task automatic reset_dut();
        rst <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int k;
        int n;
        logic [31:0] q;
        logic e;
        reset_dut();
        rd(`OFS_CTRL, 32'h0, "ctrl reset");
        rd(`OFS_PINCFG, 32'h0, "pin cfg strap high");
        rd(`OFS_ACQCLK, 32'h0, "acq select reset");
        rd(`OFS_STATUS, 32'h0, "status reset");
        xfer(1'b0, 8'h18, 32'h0, q, e);
        chk("unmapped data", q, 32'h0);
        chk("unmapped error", {31'h0, e}, 32'h1);
        // Analog pins read low for every configuration
        for (k = 0; k < 16; k++) begin
            wr(`OFS_PINCFG, 32'(k));
            n = (k <= 2) ? 13 : 15 - k;
            rd(`OFS_PORT, 32'(13'h1FFF & ~((13'h0001 << n) - 13'h0001)), "port read");
        end
        for (k = 0; k < 6; k++) begin
            conv(8'h80 | {5'h00, clk_codes[k]}, 2 << k, 0, 0, 0, 16'h03FF);
        end
        for (k = 1; k < 8; k++) begin
            conv(8'(8'h80 | (k << 3)), 2, acq_lens[k - 1], 0, 0, 16'h03FF);
        end
        conv(8'h83, 12, 0, 4, 4, 16'h03FF);
        conv(8'h8F, 12, 2, 0, 4, 16'h03FF);
        conv(8'h00, 2, 0, 0, 0, 16'hFFC0);
        comparator_high <= 1'b0;
        conv(8'h80, 2, 0, 0, 0, 16'h0000);
        // Abort mid-conversion keeps the written result
        wr(`OFS_ACQCLK, 32'h86);
        wr(`OFS_RESULT, 32'h1234);
        wr(`OFS_CTRL, 32'h3);
        repeat (100) @(posedge sys_clk);
        wr(`OFS_CTRL, 32'h1);
        wait_hold(64, 0);
        rd(`OFS_RESULT, 32'h1234, "result after abort");
        rd(`OFS_STATUS, 32'h0, "no flag on abort");
        portb_analog_reset_cfg <= 1'b0;
        reset_dut();
        rd(`OFS_PINCFG, 32'h7, "pin cfg strap low");
        conclude();
    end
endmodule
